// ===== hw/smd_pkg.sv
package smd_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_NS   = 50;
  localparam int unsigned STEP_NS  = 100;
  // pwm time step in clocks, least time rounds up
  localparam int unsigned STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWM_W    = 12;

  // ----------------------------------------
  // electrical angle
  // ----------------------------------------
  localparam logic [8:0] ANGLE_LAST = 9'h17F;
  localparam logic [8:0] ANGLE_THIRD = 9'h080;
  localparam int unsigned SINE_DEPTH = 384;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_PERIOD = 12'h004;
  localparam logic [11:0] OFS_DEAD   = 12'h008;
  localparam logic [11:0] OFS_NEXT   = 12'h00C;
  localparam logic [11:0] OFS_CMP_CM = 12'h010;
  localparam logic [11:0] OFS_CMP_PD = 12'h014;
  localparam logic [11:0] OFS_CMP_FL = 12'h018;
  localparam logic [11:0] OFS_CAPT   = 12'h01C;
  localparam logic [11:0] OFS_ANGPER = 12'h020;
  localparam logic [11:0] OFS_VOLT   = 12'h024;
  localparam logic [11:0] OFS_DUTY   = 12'h028;
  localparam logic [11:0] OFS_STATUS = 12'h02C;
  localparam logic [11:0] OFS_KEY    = 12'h030;
  localparam logic [11:0] SINE_BASE  = 12'h800;

  // ----------------------------------------
  // control bits and reset values
  // ----------------------------------------
  localparam int unsigned CB_PWM  = 0;
  localparam int unsigned CB_POS  = 1;
  localparam int unsigned CB_EMG  = 2;
  localparam int unsigned CB_SRC  = 3;
  localparam int unsigned CB_SINE = 4;
  localparam int unsigned CB_LOW  = 5;
  localparam int unsigned CB_TMR  = 6;
  localparam logic [6:0]  CTRL_RST   = 7'h04;
  localparam logic [11:0] PERIOD_RST = 12'hFFF;
  localparam logic [7:0]  DEAD_RST   = 8'h04;
  localparam logic [7:0]  BLANK_RST  = 8'h08;
  localparam logic [3:0]  RATE_RST   = 4'h1;
  localparam logic [3:0]  MATCH_RST  = 4'h3;
  localparam logic [7:0]  EMG_KEY1   = 8'h5A;
  localparam logic [7:0]  EMG_KEY2   = 8'hA5;

  typedef enum logic [1:0] {SMD_RUN, SMD_STOP, SMD_ARMED} smd_stop_t;
endpackage : smd_pkg

// ===== hw/smd_pwm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface smd_pwm_if;
  logic        enable;
  logic [11:0] period;
  logic [7:0]  dead;
  logic [11:0] duty [3];
  logic [2:0]  on;
  logic        on_start;
  logic        period_end;

  modport core (output enable, period, dead, duty, input on, on_start, period_end);
  modport gen  (input enable, period, dead, duty, output on, on_start, period_end);
endinterface : smd_pwm_if
`default_nettype wire

// ===== hw/smd_pwm_gen.sv
`timescale 1ns/1ns
`default_nettype none
module smd_pwm_gen #(
  parameter int unsigned CNT_W = smd_pkg::PWM_W
) (
  input  wire logic pclk,
  input  wire logic presetn,
  smd_pwm_if.gen    pw
);
  initial begin
    if (CNT_W != 12) $error("smd_pwm_gen: counter must be 12 bits");
  end

  logic [1:0]       pre;
  logic             tick;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] duty_act [3];
  logic [7:0]       dc [3];
  logic [2:0]       raw;

  // ----------------------------------------
  // time step and period counter
  // ----------------------------------------
  assign tick = (pre == 2'(smd_pkg::STEP_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 2'h0;
    end else if (!pw.enable || tick) begin
      pre <= 2'h0;
    end else begin
      pre <= pre + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt           <= '0;
      pw.period_end <= 1'b0;
    end else begin
      pw.period_end <= 1'b0;
      if (!pw.enable) begin
        cnt <= '0;
      end else if (tick) begin
        if (cnt >= pw.period - 12'h001) begin
          cnt           <= '0;
          pw.period_end <= 1'b1;
        end else begin
          cnt <= cnt + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) duty_act[i] <= '0;
    end else if (!pw.enable || (tick && cnt >= pw.period - 12'h001)) begin
      for (int i = 0; i < 3; i++) duty_act[i] <= pw.duty[i];
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) raw[i] = pw.enable && (cnt < duty_act[i]);
  end

  // ----------------------------------------
  // dead time at turn-on, counted in steps
  // ----------------------------------------
  // delayed turn-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) dc[i] <= 8'h00;
      pw.on       <= 3'b000;
      pw.on_start <= 1'b0;
    end else begin
      pw.on_start <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (!raw[i]) begin
          dc[i]    <= 8'h00;
          pw.on[i] <= 1'b0;
        end else if (dc[i] >= pw.dead) begin
          if (!pw.on[i]) pw.on_start <= 1'b1;
          pw.on[i] <= 1'b1;
        end else if (tick) begin
          dc[i] <= dc[i] + 8'h01;
        end
      end
    end
  end
endmodule : smd_pwm_gen
`default_nettype wire

// ===== hw/smd_core.sv
// Summary of operation
// - modes 0..5 drive one upper and one lower switch: u-y u-z v-z v-x w-x w-y.
// - only the upper or only the lower conducting switch carries pwm.
// - pwm period and duty are 12-bit in 100 ns steps.
// - pwm event pulses once every programmable number of pwm periods.
// - a programmable dead time precedes every pwm turn-on.
// - position detected after a programmable number of consecutive matches.
// - sampling blanked for a programmable time after each pwm turn-on.
// - timer has one magnitude and two equality compare channels synced to detection.
// - low emergency input or timer failure compare stops all drive at once.
// - leaving stop needs a two-write key sequence.
// - next pattern loads into outputs on detection or timer event.
// - a timer compare starts position sampling by itself.
// - electrical angle counts 0..383 at programmable rate and feeds duty calc.
// - phase duty = sine ram data times voltage amplitude / 256 at the phase's angle.
// - timer gives commutation, detection start and failure check events.
// - emergency circuit enabled at reset; software holds input high or disables.
`timescale 1ns/1ns
`default_nettype none
module smd_core #(
  parameter int unsigned SINE_N = smd_pkg::SINE_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  position_in,
  input  wire logic        emergency_stop_input_n,
  output logic      [2:0]  gate_upper,
  output logic      [2:0]  gate_lower,
  output logic             pwm_event,
  output logic             pos_detect,
  output logic             stop_active
);
  initial begin
    if (SINE_N != 384) $error("smd_core: angle table must hold 384 entries");
  end

  smd_pwm_if pw ();

  logic [6:0]  ctrl;
  logic [11:0] period, duty_reg;
  logic [7:0]  dead, blank, volt;
  logic [3:0]  rate, match_n;
  logic [2:0]  next_mode, active_mode, expect_pos;
  logic [15:0] cmp_cm, cmp_pd, cmp_fl, capt, tmr, ang_per, aprs;
  logic [8:0]  angle;
  logic [11:0] sine_ram [SINE_N];
  logic [11:0] duty_pend [3];
  logic [1:0]  ph;
  logic [19:0] prod;
  logic [8:0]  raddr;
  logic [2:0]  pos_s1, pos_s2;
  logic        emg_s1, emg_s2;
  logic [3:0]  hits, rc;
  logic [7:0]  bcnt;
  logic        sampling, detect, commut_ev, pd_ev, fail, trip;
  logic        acc, wr, rd, sine_hit;
  logic [8:0]  sidx;
  logic [5:0]  act_pat;
  smd_pkg::smd_stop_t st;

  // maps a mode to {lower, upper} switch masks
  function automatic logic [5:0] pat(input logic [2:0] m);
    unique case (m)
      3'd0:    pat = 6'b010_001;
      3'd1:    pat = 6'b100_001;
      3'd2:    pat = 6'b100_010;
      3'd3:    pat = 6'b001_010;
      3'd4:    pat = 6'b001_100;
      3'd5:    pat = 6'b010_100;
      default: pat = 6'b000_000;
    endcase
  endfunction

  // adds two angles modulo one electrical turn
  function automatic logic [8:0] ang_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s > {1'b0, smd_pkg::ANGLE_LAST}) s = s - 10'(SINE_N);
    ang_add = s[8:0];
  endfunction

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  assign acc      = psel && penable && pready;
  assign wr       = acc && pwrite;
  assign rd       = acc && !pwrite;
  assign sine_hit = paddr[11];
  assign sidx     = paddr[10:2];

  // ready pulses for one cycle per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !sine_hit && paddr > smd_pkg::OFS_KEY;
    end
  end

  // read data is registered together with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      if (sine_hit) begin
        prdata <= (sidx < 9'(SINE_N)) ? {20'h0_0000, sine_ram[sidx]} : 32'h0000_0000;
      end else begin
        unique case (paddr)
          smd_pkg::OFS_CTRL:   prdata <= {25'h0, ctrl};
          smd_pkg::OFS_PERIOD: prdata <= {20'h0, period};
          smd_pkg::OFS_DEAD:   prdata <= {12'h0, rate, blank, dead};
          smd_pkg::OFS_NEXT:   prdata <= {20'h0, match_n, 1'b0, expect_pos, 1'b0, next_mode};
          smd_pkg::OFS_CMP_CM: prdata <= {16'h0, cmp_cm};
          smd_pkg::OFS_CMP_PD: prdata <= {16'h0, cmp_pd};
          smd_pkg::OFS_CMP_FL: prdata <= {16'h0, cmp_fl};
          smd_pkg::OFS_CAPT:   prdata <= {16'h0, capt};
          smd_pkg::OFS_ANGPER: prdata <= {16'h0, ang_per};
          smd_pkg::OFS_VOLT:   prdata <= {24'h0, volt};
          smd_pkg::OFS_DUTY:   prdata <= {20'h0, duty_reg};
          smd_pkg::OFS_STATUS: prdata <= {7'h0, angle, hits, 3'h0, pos_s2, sampling, 1'b0, active_mode,
                                          st != smd_pkg::SMD_RUN};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // emergency enabled at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= smd_pkg::CTRL_RST;
      period     <= smd_pkg::PERIOD_RST;
      dead       <= smd_pkg::DEAD_RST;
      blank      <= smd_pkg::BLANK_RST;
      rate       <= smd_pkg::RATE_RST;
      match_n    <= smd_pkg::MATCH_RST;
      next_mode  <= 3'h0;
      expect_pos <= 3'h0;
      cmp_cm     <= 16'hFFFF;
      cmp_pd     <= 16'hFFFF;
      cmp_fl     <= 16'hFFFF;
      ang_per    <= 16'hFFFF;
      volt       <= 8'h00;
      duty_reg   <= 12'h000;
    end else if (wr && !sine_hit) begin
      unique case (paddr)
        smd_pkg::OFS_CTRL:   ctrl <= pwdata[6:0];
        smd_pkg::OFS_PERIOD: period <= pwdata[11:0];
        smd_pkg::OFS_DEAD:   {rate, blank, dead} <= pwdata[19:0];
        smd_pkg::OFS_NEXT:   {match_n, expect_pos, next_mode} <= {pwdata[11:8], pwdata[6:4], pwdata[2:0]};
        smd_pkg::OFS_CMP_CM: cmp_cm <= pwdata[15:0];
        smd_pkg::OFS_CMP_PD: cmp_pd <= pwdata[15:0];
        smd_pkg::OFS_CMP_FL: cmp_fl <= pwdata[15:0];
        smd_pkg::OFS_ANGPER: ang_per <= pwdata[15:0];
        smd_pkg::OFS_VOLT:   volt <= pwdata[7:0];
        smd_pkg::OFS_DUTY:   duty_reg <= pwdata[11:0];
        default:             ;
      endcase
    end
  end

  // sine table written by software, one entry per word
  always_ff @(posedge pclk) begin
    if (wr && sine_hit && sidx < 9'(SINE_N)) sine_ram[sidx] <= pwdata[11:0];
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_s1 <= 3'h0;
      pos_s2 <= 3'h0;
      emg_s1 <= 1'b1;
      emg_s2 <= 1'b1;
    end else begin
      pos_s1 <= position_in;
      pos_s2 <= pos_s1;
      emg_s1 <= emergency_stop_input_n;
      emg_s2 <= emg_s1;
    end
  end

  // ----------------------------------------
  // timer unit
  // ----------------------------------------
  // two equality, one magnitude compare
  assign commut_ev = ctrl[smd_pkg::CB_TMR] && tmr == cmp_cm;
  assign pd_ev     = ctrl[smd_pkg::CB_TMR] && tmr == cmp_pd;
  assign fail      = ctrl[smd_pkg::CB_TMR] && tmr >= cmp_fl;

  // mode time restarts at each detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr  <= 16'h0000;
      capt <= 16'h0000;
    end else if (!ctrl[smd_pkg::CB_TMR]) begin
      tmr <= 16'h0000;
    end else if (detect) begin
      capt <= tmr;
      tmr  <= 16'h0000;
    end else if (tmr != 16'hFFFF) begin
      tmr <= tmr + 16'h0001;
    end
  end

  // ----------------------------------------
  // position detection
  // ----------------------------------------
  assign detect = sampling && bcnt == 8'h00 && pos_s2 == expect_pos
                  && hits + 4'h1 >= (match_n == 4'h0 ? 4'h1 : match_n);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= 8'h00;
    end else if (pw.on_start) begin
      bcnt <= blank;
    end else if (bcnt != 8'h00) begin
      bcnt <= bcnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampling   <= 1'b0;
      hits       <= 4'h0;
      pos_detect <= 1'b0;
    end else begin
      pos_detect <= detect;
      if (!ctrl[smd_pkg::CB_POS]) begin
        sampling <= 1'b0;
        hits     <= 4'h0;
      end else if (detect) begin
        sampling <= 1'b0;
        hits     <= 4'h0;
      end else if (pd_ev && !sampling) begin
        sampling <= 1'b1;
        hits     <= 4'h0;
      end else if (sampling && bcnt == 8'h00) begin
        hits <= (pos_s2 == expect_pos) ? hits + 4'h1 : 4'h0;
      end
    end
  end

  // ----------------------------------------
  // auto commutation and emergency stop
  // ----------------------------------------
  // buffered pattern transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_mode <= 3'h0;
    end else if (ctrl[smd_pkg::CB_SRC] ? commut_ev : detect) begin
      active_mode <= next_mode;
    end
  end

  assign trip = (ctrl[smd_pkg::CB_EMG] && !emg_s2) || fail;

  // two-key release, a trip always wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= smd_pkg::SMD_RUN;
    end else if (trip) begin
      st <= smd_pkg::SMD_STOP;
    end else if (wr && !sine_hit) begin
      unique case (st)
        smd_pkg::SMD_RUN:   st <= smd_pkg::SMD_RUN;
        smd_pkg::SMD_STOP:  if (paddr == smd_pkg::OFS_KEY && pwdata[7:0] == smd_pkg::EMG_KEY1) begin
          st <= smd_pkg::SMD_ARMED;
        end
        smd_pkg::SMD_ARMED: if (paddr == smd_pkg::OFS_KEY && pwdata[7:0] == smd_pkg::EMG_KEY2) begin
          st <= smd_pkg::SMD_RUN;
        end else begin
          st <= smd_pkg::SMD_STOP;
        end
        default:            st <= smd_pkg::SMD_STOP;
      endcase
    end
  end

  // ----------------------------------------
  // electrical angle and duty calculation
  // ----------------------------------------
  // angle 0..383
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aprs  <= 16'h0000;
      angle <= 9'h000;
    end else if (!ctrl[smd_pkg::CB_SINE]) begin
      aprs <= 16'h0000;
    end else if (aprs >= ang_per) begin
      aprs  <= 16'h0000;
      angle <= (angle == smd_pkg::ANGLE_LAST) ? 9'h000 : angle + 9'h001;
    end else begin
      aprs <= aprs + 16'h0001;
    end
  end

  // one phase per cycle, 120 degrees apart
  assign raddr = ang_add(angle, ph == 2'd0 ? 9'h000 : (ph == 2'd1 ? smd_pkg::ANGLE_THIRD
                         : ang_add(smd_pkg::ANGLE_THIRD, smd_pkg::ANGLE_THIRD)));
  assign prod  = {8'h00, sine_ram[raddr]} * {12'h000, volt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 2'd0;
      for (int i = 0; i < 3; i++) duty_pend[i] <= 12'h000;
    end else begin
      ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
      duty_pend[ph] <= ctrl[smd_pkg::CB_SINE] ? prod[19:8] : duty_reg;
    end
  end

  // ----------------------------------------
  // pwm generator and gate outputs
  // ----------------------------------------
  assign pw.enable = ctrl[smd_pkg::CB_PWM] && st == smd_pkg::SMD_RUN;
  assign pw.period = period;
  assign pw.dead   = dead;
  assign pw.duty   = duty_pend;

  smd_pwm_gen u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .pw      (pw)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc        <= 4'h0;
      pwm_event <= 1'b0;
    end else begin
      pwm_event <= 1'b0;
      if (pw.period_end) begin
        if (rc + 4'h1 >= rate) begin
          rc        <= 4'h0;
          pwm_event <= 1'b1;
        end else begin
          rc <= rc + 4'h1;
        end
      end
    end
  end

  // switch masks of the active mode, a call result cannot be sliced
  assign act_pat = pat(active_mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_upper  <= 3'b000;
      gate_lower  <= 3'b000;
      stop_active <= 1'b0;
    end else begin
      stop_active <= st != smd_pkg::SMD_RUN || trip;
      if (trip || !pw.enable) begin
        gate_upper <= 3'b000;
        gate_lower <= 3'b000;
      end else begin
        gate_upper <= act_pat[2:0] & (ctrl[smd_pkg::CB_LOW] ? 3'b111 : pw.on);
        gate_lower <= act_pat[5:3] & (ctrl[smd_pkg::CB_LOW] ? pw.on : 3'b111);
      end
    end
  end
endmodule : smd_core
`default_nettype wire

// ===== verif/smd_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
module smd_core_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        emergency_stop_input_n,
  input wire logic [2:0]  gate_upper,
  input wire logic [2:0]  gate_lower,
  input wire logic        pwm_event,
  input wire logic        pos_detect,
  input wire logic        stop_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr_done;
  logic       emg_en;
  logic [3:0] key_age;
  assign wr_done = psel && penable && pready && pwrite;
  // shadow of the emergency enable, set at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) emg_en <= 1'b1;
    else if (wr_done && paddr == 12'h000) emg_en <= pwdata[2];
  end
  // cycles since the releasing key word, saturates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) key_age <= 4'hF;
    else if (wr_done && paddr == 12'h030 && pwdata[7:0] == 8'hA5) key_age <= 4'h0;
    else if (key_age != 4'hF) key_age <= key_age + 4'h1;
  end
  // ----------------
  // properties
  // ----------------
  chk_no_shoot: assert property ((gate_upper & gate_lower) == 3'h0)
    else $error("phase on at both sides");
  chk_one_pair: assert property ($onehot0(gate_upper) && $onehot0(gate_lower))
    else $error("two switches on one side");
  chk_stop_gates: assert property (stop_active |-> {gate_upper, gate_lower} == 6'h00)
    else $error("gates on while stopped");
  chk_emg_trip: assert property (!emergency_stop_input_n && emg_en |-> ##[1:4] stop_active)
    else $error("emergency input ignored");
  chk_key_release: assert property ($fell(stop_active) |-> key_age < 4'h4)
    else $error("stop left without key");
  chk_apb_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("apb answer late");
  chk_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  chk_det_pulse: assert property (pos_detect |=> !pos_detect)
    else $error("detect pulse too long");
  chk_evt_pulse: assert property (pwm_event |=> !pwm_event)
    else $error("event pulse too long");
  cover property (pos_detect);
  cover property ($fell(stop_active));
  cover property (pwm_event);
  cover property (pslverr);
endmodule // smd_core_chk
bind smd_core smd_core_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .emergency_stop_input_n, .gate_upper,
  .gate_lower, .pwm_event, .pos_detect, .stop_active);
`default_nettype wire

// ===== verif/smd_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
module smd_motor_model (
  input  wire logic       pclk,
  input  wire logic [2:0] gate_upper,
  input  wire logic [2:0] gate_lower,
  input  wire logic [2:0] pos_req,
  input  wire logic       emg_req,
  output logic      [2:0] position_in,
  output logic            emergency_stop_input_n,
  output logic            shoot
);
  // sensor and stop pins act as inputs
  // rotor sensors show the step asked for
  assign position_in = pos_req;
  // emergency high unless a trip is requested
  // line stays high unless a fault is asked for
  assign emergency_stop_input_n = !emg_req;
  // cross conduction watch
  // both switches of a phase on would short the bridge
  initial shoot = 1'b0;
  always @(posedge pclk) begin
    if ((gate_upper & gate_lower) != 3'h0) shoot <= 1'b1;
  end
endmodule // smd_motor_model
`default_nettype wire

// ===== verif/sine_motor_drive_core_test.sv
`timescale 1ns/1ns
`default_nettype none
module sine_motor_drive_core_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  pos_req = 3'h0;
  logic        emg_req = 1'b0;
  logic [31:0] prdata, q;
  logic [2:0]  position_in, gate_upper, gate_lower;
  logic        pready, pslverr, se, shoot, pwm_event, pos_detect, stop_active;
  logic        emergency_stop_input_n;
  int          error_cnt = 0;
  int          check_count = 0;
  // upper, lower and sensor pattern per mode
  localparam logic [2:0] UP [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam logic [2:0] LO [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  localparam logic [2:0] PS [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  smd_core dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .position_in, .emergency_stop_input_n, .gate_upper,
    .gate_lower, .pwm_event, .pos_detect, .stop_active);
  smd_motor_model motor (.pclk, .gate_upper, .gate_lower, .pos_req, .emg_req,
    .position_in, .emergency_stop_input_n, .shoot);
  initial forever #25 pclk = ~pclk;
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // one transfer, request held until pready is sampled
  // whole word per access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ck(n < 40, 1'b1, "apb timeout");
    if (n >= 40) conclude();
  endtask
  // bounded wait: 0 detect, 1 stop, 2 event
  task automatic wt(input int s, input int lim);
    int n;
    n = 0;
    do @(posedge pclk);
    while ((s == 0 ? pos_detect : s == 1 ? stop_active : pwm_event) !== 1'b1 && ++n < lim);
    ck(n < lim, 1'b1, "wait timeout");
    if (n >= lim) conclude();
  endtask
  task automatic s_regs();
    logic [11:0] a [4];
    logic [31:0] e [4];
    a = '{12'h000, 12'h004, 12'h008, 12'h00C};
    e = '{32'h4, 32'hFFF, 32'h10804, 32'h300};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, a[i], 32'h0);
      ck(q, e[i], "reset value");
    end
    apb(1'b0, 12'h034, 32'h0);
    ck({se, q[30:0]}, 32'h80000000, "unmapped read");
  endtask
  // every mode, lower side modulated in odd modes
  task automatic s_modes();
    logic [2:0] ou, ol, au, al;
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b1, 12'h028, 32'h8);
    apb(1'b1, 12'h014, 32'h10);
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, 12'h000, {25'h0, 1'b1, m[0], 5'h07});
      apb(1'b1, 12'h00C, {20'h0, 4'h3, 1'b0, PS[m], 1'b0, m[2:0]});
      pos_req <= PS[m];
      wt(0, 3000);
      repeat (4) @(posedge pclk);
      {ou, ol, au, al} = 12'h03F;
      repeat (80) begin
        @(posedge pclk);
        {ou, ol} = {ou | gate_upper, ol | gate_lower};
        {au, al} = {au & gate_upper, al & gate_lower};
      end
      ck({ou, ol}, {UP[m], LO[m]}, "mode pattern");
      ck({au, al}, m[0] ? {UP[m], 3'h0} : {3'h0, LO[m]}, "modulated side");
    end
    ck(shoot, 1'b0, "cross conduction");
  endtask
  // a two-clock match must not count
  task automatic s_match();
    int n;
    n = 0;
    apb(1'b1, 12'h000, 32'h46);
    apb(1'b1, 12'h00C, {20'h0, 4'h3, 1'b0, PS[2], 4'h2});
    pos_req <= PS[0];
    repeat (60) @(posedge pclk);
    pos_req <= PS[2];
    repeat (2) @(posedge pclk);
    pos_req <= PS[0];
    repeat (12) begin
      @(posedge pclk);
      n += int'(pos_detect === 1'b1);
    end
    ck(n, 0, "short match detected");
    pos_req <= PS[2];
    wt(0, 40);
  endtask
  task automatic s_rate();
    int t1, t3;
    apb(1'b1, 12'h000, 32'h05);
    wt(2, 200);
    t1 = int'($time / 50);
    wt(2, 200);
    t1 = int'($time / 50) - t1;
    apb(1'b1, 12'h008, 32'h30804);
    wt(2, 400);
    t3 = int'($time / 50);
    wt(2, 400);
    t3 = int'($time / 50) - t3;
    ck(t1, 32, "pwm period");
    ck(t3, 3 * t1, "event rate");
  endtask
  // trip, stray key, proper key, then failure compare
  task automatic s_emg();
    apb(1'b1, 12'h000, 32'h47);
    emg_req <= 1'b1;
    wt(1, 10);
    repeat (2) @(posedge pclk);
    ck({gate_upper, gate_lower}, 6'h00, "gates in stop");
    emg_req <= 1'b0;
    repeat (10) @(posedge pclk);
    ck(stop_active, 1'b1, "stop held");
    apb(1'b1, 12'h030, 32'h5A);
    apb(1'b1, 12'h030, 32'h00);
    apb(1'b1, 12'h030, 32'hA5);
    repeat (3) @(posedge pclk);
    ck(stop_active, 1'b1, "stray key released");
    apb(1'b1, 12'h030, 32'h5A);
    apb(1'b1, 12'h030, 32'hA5);
    repeat (3) @(posedge pclk);
    ck(stop_active, 1'b0, "key release");
    pos_req <= PS[0];
    apb(1'b1, 12'h018, 32'h40);
    wt(1, 300);
  endtask
  // sine word, angle step, timer commutation, then all off
  task automatic s_sine();
    logic [31:0] a1;
    apb(1'b1, 12'h804, 32'hABC);
    apb(1'b0, 12'h804, 32'h0);
    ck(q, 32'hABC, "sine word");
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b0, 12'h02C, 32'h0);
    a1 = q;
    apb(1'b0, 12'h02C, 32'h0);
    ck((q[24:16] + 10'd384 - a1[24:16]) % 10'd384, 4, "angle step");
    apb(1'b1, 12'h010, 32'h8);
    apb(1'b1, 12'h00C, 32'h4);
    apb(1'b1, 12'h000, 32'h48);
    repeat (12) @(posedge pclk);
    apb(1'b0, 12'h02C, 32'h0);
    ck(q[3:1], 3'h4, "timer commutation");
    apb(1'b1, 12'h000, 32'h0);
    ck({gate_upper, gate_lower}, 6'h00, "drive left on");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_modes();
    s_match();
    s_rate();
    s_emg();
    s_sine();
    conclude();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    ck(0, 1, "run timeout");
    conclude();
  end
endmodule // sine_motor_drive_core_test
`default_nettype wire
